// >>> group_status_pkg.sv
// Constants and types for the shared status group block
// Contract
// - Eight members share one 8-bit data bus
// - Control bit 0 enables group participation
// - Control bits 1-3 pick driven data line
// - Interrupt group read drives pending status
// - Sync-loss group read drives frame sync status
// - First user read drives selector-chosen alarm
// - Second user read uses second selector
// - Control registers at B0h, B1h, reset zero
// - Three shared pins coordinate group reads
package group_status_pkg;
  localparam int DATA_WIDTH = 8;
  localparam int GROUP_MEMBERS = 8;
  localparam int SEL_WIDTH = 3;
  localparam logic [7:0] ADDR_CTRL_ENABLE_LINE = 8'hB0;
  localparam logic [7:0] ADDR_CTRL_USER_SELECT = 8'hB1;
  localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'hB2;
  localparam logic [7:0] ADDR_SYNC_LOSS_STATUS = 8'hB3;
  localparam logic [7:0] ADDR_USER_STATUS_ONE = 8'hB4;
  localparam logic [7:0] ADDR_USER_STATUS_TWO = 8'hB5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int ENABLE_BIT = 0;
  localparam int LINE_SEL_LSB = 1;
  localparam int USER_ONE_LSB = 0;
  localparam int USER_TWO_LSB = 4;
  // Alarm selector codes; T1 name first, E1 name second
  localparam logic [2:0] PICK_BPV_OR_ALL_ONES = 3'h0;
  localparam logic [2:0] PICK_YELLOW_OR_REMOTE = 3'h1;
  localparam logic [2:0] PICK_LOOP_UP_OR_MF_REMOTE = 3'h2;
  localparam logic [2:0] PICK_LOOP_DOWN_OR_V52 = 3'h3;
  localparam logic [2:0] PICK_SIGNALING_CHANGE = 3'h4;
  localparam logic [2:0] PICK_SLIP = 3'h5;
  // Time the addressed member holds the group read open
  localparam int CLK_PERIOD_NS = 20;
  localparam int READ_WINDOW_NS = 200;
  localparam int READ_WINDOW_CYCLES = (READ_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_WIDTH = 4;

  typedef enum logic [1:0] {
    GRP_INTERRUPT,
    GRP_SYNC_LOSS,
    GRP_USER_ONE,
    GRP_USER_TWO
  } group_reg_type;

  typedef struct packed {
    logic bipolar_loss_alarm;
    logic yellow_alarm;
    logic loop_up_detect;
    logic loop_down_detect;
    logic unframed_all_ones;
    logic remote_alarm;
    logic multiframe_remote_alarm;
    logic v52_link_detect;
    logic signaling_change;
    logic elastic_store_slip;
  } alarm_set_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  // Shared open-drain group pins, one bit per pin
  typedef struct packed {
    logic group_read_strobe;
    logic group_select_line_1;
    logic group_select_line_0;
  } group_pins_type;
endpackage

// >>> pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Pin side and clean side
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] clean
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_clean;

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  // A bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_clean[i] = (stage2[i] == stage3[i]) ? stage3[i] : clean[i];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= IDLE_LEVEL;
      stage2 <= IDLE_LEVEL;
      stage3 <= IDLE_LEVEL;
      clean <= IDLE_LEVEL;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      clean <= next_clean;
    end
  end
endmodule

// >>> user_status_pick.sv
// Picks one alarm condition from a three-bit selector and line mode
`timescale 1ns/10ps
module user_status_pick
  import group_status_pkg::*;
(
  // Selection
  input wire logic [SEL_WIDTH-1:0] pick,
  input wire logic e1_mode,
  // Alarm sources and result
  input wire alarm_set_type alarms,
  output logic status_bit
);
  always_comb begin
    case (pick)
      PICK_BPV_OR_ALL_ONES: begin
        status_bit = e1_mode ? alarms.unframed_all_ones : alarms.bipolar_loss_alarm;
      end
      PICK_YELLOW_OR_REMOTE: begin
        status_bit = e1_mode ? alarms.remote_alarm : alarms.yellow_alarm;
      end
      PICK_LOOP_UP_OR_MF_REMOTE: begin
        status_bit = e1_mode ? alarms.multiframe_remote_alarm : alarms.loop_up_detect;
      end
      PICK_LOOP_DOWN_OR_V52: begin
        status_bit = e1_mode ? alarms.v52_link_detect : alarms.loop_down_detect;
      end
      PICK_SIGNALING_CHANGE: status_bit = alarms.signaling_change;
      PICK_SLIP: status_bit = alarms.elastic_store_slip;
      // Undefined codes report no alarm
      default: status_bit = 1'b0;
    endcase
  end
endmodule

// >>> group_status_bus.sv
// Shared status group extension of the parallel host port
`timescale 1ns/10ps
module group_status_bus
  import group_status_pkg::*;
#(
  parameter int WINDOW_CYCLES = READ_WINDOW_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Host register port, same clock domain
  input wire host_req_type host_req,
  output logic [DATA_WIDTH-1:0] host_rdata,
  output logic [DATA_WIDTH-1:0] host_data_oe,
  output logic read_done,
  // Local status sources
  input wire logic e1_mode,
  input wire logic member_interrupt_bit,
  input wire logic member_sync_loss_bit,
  input wire alarm_set_type alarms,
  // Shared open-drain group pins
  input wire group_pins_type group_in,
  output group_pins_type group_out,
  output group_pins_type group_oe
);
  typedef enum logic [1:0] {IDLE, OWN_READ, PEER_DRIVE, SETTLE} state_type;

  state_type state;
  state_type next_state;
  logic [CNT_WIDTH-1:0] count;
  logic [CNT_WIDTH-1:0] next_count;
  group_reg_type active_reg;
  group_reg_type next_active_reg;
  logic group_read;
  logic next_group_read;
  logic [7:0] ctrl_enable_line;
  logic [7:0] ctrl_user_select;
  logic [7:0] next_ctrl_enable_line;
  logic [7:0] next_ctrl_user_select;
  logic [DATA_WIDTH-1:0] next_host_rdata;
  logic [DATA_WIDTH-1:0] next_host_data_oe;
  logic next_read_done;
  group_pins_type next_group_oe;
  group_pins_type pins_clean;
  logic participate;
  logic [SEL_WIDTH-1:0] line_sel;
  logic [DATA_WIDTH-1:0] line_onehot;
  logic user_one_bit;
  logic user_two_bit;
  logic own_bit;
  logic req_group;
  group_reg_type req_reg;
  group_reg_type peer_reg;
  logic peer_strobe;

  // Shorter windows release our strobe before the synchroniser sees it,
  // so the late echo would be taken for a peer read
  localparam int MIN_WINDOW = 4;
  localparam int LAST_HELD = WINDOW_CYCLES - 1;
  localparam int DONE_DELAY = WINDOW_CYCLES + 1;

  initial begin
    if (WINDOW_CYCLES < MIN_WINDOW || WINDOW_CYCLES >= (1 << CNT_WIDTH)) begin
      $error("WINDOW_CYCLES out of range for the window counter");
    end
  end

  pin_sync #(
    .WIDTH($bits(group_pins_type)),
    .IDLE_LEVEL('1)
  ) u_pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin(group_in),
    .clean(pins_clean)
  );

  user_status_pick u_pick_one (
    .pick(ctrl_user_select[USER_ONE_LSB +: SEL_WIDTH]),
    .e1_mode(e1_mode),
    .alarms(alarms),
    .status_bit(user_one_bit)
  );

  user_status_pick u_pick_two (
    .pick(ctrl_user_select[USER_TWO_LSB +: SEL_WIDTH]),
    .e1_mode(e1_mode),
    .alarms(alarms),
    .status_bit(user_two_bit)
  );

  assign participate = ctrl_enable_line[ENABLE_BIT];
  assign line_sel = ctrl_enable_line[LINE_SEL_LSB +: SEL_WIDTH];
  assign line_onehot = DATA_WIDTH'(1) << line_sel;
  // Strobe is active low; pull-ups hold it high between reads
  assign peer_strobe = !pins_clean.group_read_strobe;
  assign peer_reg = group_reg_type'({pins_clean.group_select_line_1,
                                     pins_clean.group_select_line_0});

  always_comb begin
    req_group = 1'b1;
    req_reg = GRP_INTERRUPT;
    case (host_req.addr)
      ADDR_INTERRUPT_STATUS: req_reg = GRP_INTERRUPT;
      ADDR_SYNC_LOSS_STATUS: req_reg = GRP_SYNC_LOSS;
      ADDR_USER_STATUS_ONE: req_reg = GRP_USER_ONE;
      ADDR_USER_STATUS_TWO: req_reg = GRP_USER_TWO;
      default: req_group = 1'b0;
    endcase
  end

  // Own bit for the register in play this cycle
  always_comb begin
    case (next_active_reg)
      GRP_INTERRUPT: own_bit = member_interrupt_bit;
      GRP_SYNC_LOSS: own_bit = member_sync_loss_bit;
      GRP_USER_ONE: own_bit = user_one_bit;
      GRP_USER_TWO: own_bit = user_two_bit;
      default: own_bit = 1'b0;
    endcase
  end

  // Control registers; unused bits store whatever software writes
  always_comb begin
    next_ctrl_enable_line = ctrl_enable_line;
    next_ctrl_user_select = ctrl_user_select;
    if (host_req.wr) begin
      if (host_req.addr == ADDR_CTRL_ENABLE_LINE) begin
        next_ctrl_enable_line = host_req.wdata;
      end
      if (host_req.addr == ADDR_CTRL_USER_SELECT) begin
        next_ctrl_user_select = host_req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_enable_line <= CTRL_RESET;
      ctrl_user_select <= CTRL_RESET;
    end else begin
      ctrl_enable_line <= next_ctrl_enable_line;
      ctrl_user_select <= next_ctrl_user_select;
    end
  end

  // Read sequencer: own reads, peer-driven reads, and settle time
  always_comb begin
    next_state = state;
    next_count = count;
    next_active_reg = active_reg;
    next_group_read = group_read;
    next_read_done = 1'b0;
    next_group_oe = '0;
    case (state)
      IDLE: begin
        next_group_read = 1'b0;
        if (host_req.rd) begin
          next_state = OWN_READ;
          next_count = CNT_WIDTH'(WINDOW_CYCLES - 1);
          next_group_read = req_group;
          next_active_reg = req_reg;
        end else if (peer_strobe && participate) begin
          next_state = PEER_DRIVE;
          next_group_read = 1'b1;
          next_active_reg = peer_reg;
        end
      end
      OWN_READ: begin
        if (count == '0) begin
          next_state = group_read ? SETTLE : IDLE;
          next_read_done = 1'b1;
          next_group_read = 1'b0;
        end else begin
          next_count = count - CNT_WIDTH'(1);
        end
      end
      PEER_DRIVE: begin
        if (!peer_strobe || !participate) begin
          next_state = IDLE;
          next_group_read = 1'b0;
        end
      end
      // Wait for our own strobe to clear the synchroniser
      SETTLE: begin
        if (!peer_strobe) begin
          next_state = IDLE;
        end
      end
      default: begin
        next_state = IDLE;
        next_group_read = 1'b0;
      end
    endcase
    // Pull a select line low for a zero bit of the register code
    if (next_state == OWN_READ && next_group_read) begin
      next_group_oe.group_read_strobe = 1'b1;
      next_group_oe.group_select_line_0 = !next_active_reg[0];
      next_group_oe.group_select_line_1 = !next_active_reg[1];
    end
  end

  // Data bus drive: group reads touch one line when enabled and none when not, local reads all eight
  always_comb begin
    next_host_rdata = '0;
    next_host_data_oe = '0;
    if (next_state == OWN_READ && !next_group_read) begin
      next_host_data_oe = '1;
      if (next_state != state) begin
        case (host_req.addr)
          ADDR_CTRL_ENABLE_LINE: next_host_rdata = ctrl_enable_line;
          ADDR_CTRL_USER_SELECT: next_host_rdata = ctrl_user_select;
          default: next_host_rdata = UNMAPPED_READ;
        endcase
      end else begin
        next_host_rdata = host_rdata;
      end
    end else if ((next_state == OWN_READ || next_state == PEER_DRIVE)
                 && next_group_read && participate) begin
      next_host_data_oe = line_onehot;
      next_host_rdata = own_bit ? line_onehot : '0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= IDLE;
      count <= '0;
      active_reg <= GRP_INTERRUPT;
      group_read <= 1'b0;
      host_rdata <= '0;
      host_data_oe <= '0;
      read_done <= 1'b0;
      group_oe <= '0;
      group_out <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
      active_reg <= next_active_reg;
      group_read <= next_group_read;
      host_rdata <= next_host_rdata;
      host_data_oe <= next_host_data_oe;
      read_done <= next_read_done;
      group_oe <= next_group_oe;
      // Open drain: level is always low, only the enable moves
      group_out <= '0;
    end
  end

  // Checks
  logic own_group_start;
  assign own_group_start = state == IDLE && host_req.rd && req_group;

  chk_single_line: assert property (@(posedge core_clk) disable iff (!resetn)
    group_read |-> $countones(host_data_oe) <= 1)
    else $error("group read drives more than one data line");

  chk_line_select: assert property (@(posedge core_clk) disable iff (!resetn)
    group_read && participate && $stable(ctrl_enable_line)
    |-> host_data_oe == line_onehot)
    else $error("group read drives the wrong data line");

  // Local reads drive all eight lines whatever the enable says
  chk_disabled_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    !$past(participate) && !participate && (state != OWN_READ || group_read)
    |-> host_data_oe == '0)
    else $error("disabled member drives the data bus");

  chk_interrupt_bit: assert property (@(posedge core_clk) disable iff (!resetn)
    group_read && active_reg == GRP_INTERRUPT && participate && $stable(ctrl_enable_line)
    |-> host_rdata[line_sel] == $past(member_interrupt_bit))
    else $error("interrupt status bit wrong on group read");

  chk_sync_bit: assert property (@(posedge core_clk) disable iff (!resetn)
    group_read && active_reg == GRP_SYNC_LOSS && participate && $stable(ctrl_enable_line)
    |-> host_rdata[line_sel] == $past(member_sync_loss_bit))
    else $error("sync loss bit wrong on group read");

  chk_user_one: assert property (@(posedge core_clk) disable iff (!resetn)
    group_read && active_reg == GRP_USER_ONE && participate && $stable(ctrl_enable_line)
    |-> host_rdata[line_sel] == $past(user_one_bit))
    else $error("first user status bit wrong");

  chk_user_two: assert property (@(posedge core_clk) disable iff (!resetn)
    group_read && active_reg == GRP_USER_TWO && participate && $stable(ctrl_enable_line)
    |-> host_rdata[line_sel] == $past(user_two_bit))
    else $error("second user status bit wrong");

  chk_strobe_window: assert property (@(posedge core_clk) disable iff (!resetn)
    own_group_start |=> group_oe.group_read_strobe ##LAST_HELD group_oe.group_read_strobe
    ##1 !group_oe.group_read_strobe)
    else $error("group strobe not held through the read window");

  // Done pulse follows the last cycle of the window
  chk_read_done: assert property (@(posedge core_clk) disable iff (!resetn)
    own_group_start |-> ##DONE_DELAY read_done)
    else $error("read window length wrong");

  chk_ctrl_write: assert property (@(posedge core_clk) disable iff (!resetn)
    host_req.wr && host_req.addr == ADDR_CTRL_ENABLE_LINE
    |=> ctrl_enable_line == $past(host_req.wdata))
    else $error("control write not stored");

  cov_own_group: cover property (@(posedge core_clk) disable iff (!resetn)
    own_group_start && participate);
  cov_peer_drive: cover property (@(posedge core_clk) disable iff (!resetn)
    state == PEER_DRIVE && host_data_oe != '0);
  cov_user_e1: cover property (@(posedge core_clk) disable iff (!resetn)
    group_read && active_reg == GRP_USER_TWO && e1_mode);
endmodule

// >>> peer_member.sv
// Behavioural peer member that opens group reads over the shared pins
`timescale 1ns/10ps
module peer_member
  import group_status_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bench control
  input wire logic go,
  input wire logic [1:0] code,
  input wire logic [4:0] hold,
  // Pulls on the shared pins, high pulls low
  output group_pins_type peer_oe
);
  logic [4:0] left;
  logic [4:0] next_left;
  group_pins_type next_oe;

  // Selects carry the code by level and stay put while the strobe is low
  always_comb begin
    next_left = left;
    next_oe = peer_oe;
    if (go && left == 5'h00) begin
      next_left = hold;
      next_oe = {1'b1, ~code[1], ~code[0]};
    end else if (left != 5'h00) begin
      next_left = left - 5'h01;
      if (left == 5'h01) begin
        next_oe = '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      left <= 5'h00;
      peer_oe <= '0;
    end else begin
      left <= next_left;
      peer_oe <= next_oe;
    end
  end
endmodule

// >>> group_status_bus_test.sv
// Self-checking bench for the shared status group block
`timescale 1ns/10ps
module group_status_bus_test;
  import group_status_pkg::*;
  localparam int WIN = 4;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  host_req_type host_req = '0;
  logic [7:0] host_rdata, host_data_oe;
  logic read_done, e1_mode = 1'b0, m_int = 1'b0, m_sync = 1'b0;
  alarm_set_type alarms = '0;
  group_pins_type group_in, group_out, group_oe, peer_oe;
  logic go = 1'b0;
  logic [1:0] code = 2'h0;
  int n_fail = 0;
  int tests_run = 0;

  always #10 core_clk = ~core_clk;
  // Pull-ups hold each pin high unless someone pulls it
  assign group_in = group_pins_type'(~(group_oe | peer_oe));

  group_status_bus #(.WINDOW_CYCLES(WIN)) i_group_status_bus (
    .core_clk(core_clk), .resetn(resetn), .host_req(host_req),
    .host_rdata(host_rdata), .host_data_oe(host_data_oe), .read_done(read_done),
    .e1_mode(e1_mode), .member_interrupt_bit(m_int), .member_sync_loss_bit(m_sync),
    .alarms(alarms), .group_in(group_in), .group_out(group_out), .group_oe(group_oe));

  peer_member i_peer_member (.core_clk(core_clk), .resetn(resetn), .go(go),
    .code(code), .hold(5'h0C), .peer_oe(peer_oe));

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic pick_exp(logic [2:0] c, logic e1, alarm_set_type a);
    case (c)
      3'h0: return e1 ? a.unframed_all_ones : a.bipolar_loss_alarm;
      3'h1: return e1 ? a.remote_alarm : a.yellow_alarm;
      3'h2: return e1 ? a.multiframe_remote_alarm : a.loop_up_detect;
      3'h3: return e1 ? a.v52_link_detect : a.loop_down_detect;
      3'h4: return a.signaling_change;
      3'h5: return a.elastic_store_slip;
      default: return 1'b0;
    endcase
  endfunction

  task automatic host_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk); #1;
    host_req.wr = 1'b1; host_req.addr = a; host_req.wdata = d;
    @(posedge core_clk); #1;
    host_req.wr = 1'b0;
  endtask

  // Samples data and pin pulls in the first cycle of the window
  task automatic host_read(input logic [7:0] a, output logic [7:0] oe,
      output logic [7:0] d, output logic [2:0] g);
    int n;
    @(posedge core_clk); #1;
    host_req.rd = 1'b1; host_req.addr = a;
    @(posedge core_clk); #1;
    host_req.rd = 1'b0; oe = host_data_oe; d = host_rdata; g = group_oe;
    n = 1;
    check({5'h00, group_out}, 8'h00);
    while (read_done !== 1'b1 && n < 40) begin
      @(posedge core_clk); #1; n++;
    end
    check(8'(n), 8'(WIN + 1));
    if (n >= 40) conclude();
    // Own strobe must be seen released before the next read
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  task automatic peer_read(input logic [1:0] c, input logic en, input logic [2:0] ln,
      input logic exp);
    int n;
    logic [7:0] seen;
    @(posedge core_clk); #1; go = 1'b1; code = c;
    @(posedge core_clk); #1; go = 1'b0;
    seen = 8'h00; n = 0;
    while (seen === 8'h00 && n < 30) begin
      @(posedge core_clk); #1; seen = host_data_oe; n++;
    end
    check(seen, en ? 8'h01 << ln : 8'h00);
    if (en && seen === 8'h00) conclude();
    if (en) check(8'(host_rdata[ln]), 8'(exp));
    n = 0;
    while (host_data_oe !== 8'h00 && n < 40) begin
      @(posedge core_clk); #1; n++;
    end
    check(host_data_oe, 8'h00);
    if (host_data_oe !== 8'h00) conclude();
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  initial begin
    logic [7:0] oe, d, exp_oe;
    logic [2:0] g, ln, s1, s2;
    logic en, b;
    void'($urandom(32'h50a95a18));
    repeat (12) @(posedge core_clk);
    #1 resetn = 1'b1;
    host_read(8'hB0, oe, d, g);
    check(d, 8'h00);
    check(oe, 8'hFF);
    host_read(8'hB1, oe, d, g);
    check(d, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      ln = 3'($urandom);
      en = (i != 5 && i != 12);
      s1 = 3'(i);
      s2 = ~3'(i);
      e1_mode = i[3]; m_int = 1'($urandom); m_sync = 1'($urandom);
      alarms = 10'($urandom);
      host_write(8'hB0, {4'h0, ln, en});
      host_write(8'hB1, {1'b0, s2, 1'b0, s1});
      host_read(8'hB0, oe, d, g);
      check(d, {4'h0, ln, en});
      host_read(8'hB1, oe, d, g);
      check(d, {1'b0, s2, 1'b0, s1});
      exp_oe = en ? 8'h01 << ln : 8'h00;
      for (int r = 0; r < 4; r++) begin
        case (r)
          0: b = m_int;
          1: b = m_sync;
          2: b = pick_exp(s1, e1_mode, alarms);
          default: b = pick_exp(s2, e1_mode, alarms);
        endcase
        host_read(8'hB2 + 8'(r), oe, d, g);
        check(oe, exp_oe);
        if (en) check(8'(d[ln]), 8'(b));
        check(8'(g), {5'h00, 1'b1, ~2'(r)});
      end
    end
    $display("test group reads done");
    host_read(8'hB6, oe, d, g);
    check(d, 8'h00);
    check(oe, 8'hFF);
    $display("test unmapped read done");
    for (int c = 0; c < 5; c++) begin
      en = (c != 4);
      ln = 3'($urandom);
      m_int = 1'($urandom); m_sync = 1'($urandom);
      host_write(8'hB0, {4'h0, ln, en});
      host_write(8'hB1, 8'h54);
      b = (c[1:0] == 2'h0) ? m_int : (c[1:0] == 2'h1) ? m_sync :
          (c[1:0] == 2'h2) ? alarms.signaling_change : alarms.elastic_store_slip;
      peer_read(2'(c), en, ln, b);
    end
    $display("test peer reads done");
    resetn = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 resetn = 1'b1;
    host_read(8'hB0, oe, d, g);
    check(d, 8'h00);
    host_read(8'hB1, oe, d, g);
    check(d, 8'h00);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
